// ==== verilog/seb_board.sv ====
// Expansion board slave: 8-bit digital output and 4-bit digital input board.
// Assumes bus pins synchronous to CLK_IN; open-drain lines are resolved
// outside from the enables, with pull-ups on data and attention lines.
`timescale 1ns/1ps
`default_nettype none

module seb_board
  import seb_pkg::*;
#(
  parameter logic [2:0] THIRD_MATCH = 3'h0,
  parameter int         N_OUT       = 8,
  parameter int         N_IN        = 4
)(
  input  wire logic             CLK_IN,
  input  wire logic             RSTN_IN,
  input  wire logic             BUS_STROBE_N_IN,
  input  wire logic [2:0]       OP_SELECT_IN,
  input  wire logic [7:0]       BUS_DATA_IN,
  input  wire logic [2:0]       JUMPER_IN,
  input  wire logic [N_IN-1:0]  DIGITAL_IN,
  output logic      [7:0]       BUS_DATA_OUT,
  output logic      [7:0]       BUS_DATA_OE_OUT,
  output logic                  ATTN_REQ_N_OUT,
  output logic                  ATTN_REQ_OE_OUT,
  output logic      [N_OUT-1:0] DIGITAL_OUT
);

  if (N_IN != 4) begin : g_check
    $error("seb_board: the input register holds exactly four bits");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic            strobe_prev;
    logic            lat1;
    logic            lat2;
    logic            lat3;
    seb_unit_t       unit;
    logic            exp_sel;
    logic [3:0]      exp_reg;
    logic [7:0]      dout;
    logic [7:0]      doe;
    logic            attn;
    logic [N_IN-1:0] din_seen;
  } seb_state_t;

  seb_state_t st;
  seb_state_t next_st;
  seb_bus_t   bus;
  seb_mode_t  cat_mode;
  logic       fall;
  logic       dout_wr;
  logic       dout_clr;
  logic       own_exp;

  assign bus  = '{strobe_n: BUS_STROBE_N_IN, op: OP_SELECT_IN,
                  data: BUS_DATA_IN};
  // Act once per strobe, on its leading edge only
  assign fall = st.strobe_prev && !bus.strobe_n;
  assign own_exp = (st.exp_reg == `SEB_EXP_RESET);

  seb_cat_decode u_cat (
    .nibble_in (bus.data[3:0]),
    .mode_out  (cat_mode)
  );

  seb_dout_bank #(.N_OUT(N_OUT)) u_bank (
    .clk_in   (CLK_IN),
    .rst_n_in (RSTN_IN),
    .wr_in    (dout_wr),
    .clr_in   (dout_clr),
    .sel_in   (bus.data[`SEB_CTRL_SEL_HI:`SEB_CTRL_SEL_LO]),
    .val_in   (bus.data[`SEB_CTRL_VALUE_BIT]),
    .bits_out (DIGITAL_OUT)
  );

  // ----------------------------------------------------------------------
  // Bus operations
  // ----------------------------------------------------------------------
  always_comb begin
    next_st             = st;
    next_st.strobe_prev = bus.strobe_n;
    next_st.attn        = (DIGITAL_IN != st.din_seen);
    dout_wr             = 1'b0;
    dout_clr            = 1'b0;
    if (bus.strobe_n) begin
      // Release data lines as soon as the strobe ends
      next_st.doe = 8'h00;
    end
    if (fall) begin
      case (bus.op)
        `SEB_OP_BUS_RESET: begin
          next_st.lat1    = 1'b0;
          next_st.lat2    = 1'b0;
          next_st.lat3    = 1'b0;
          next_st.unit    = UNIT_NONE;
          next_st.exp_sel = 1'b0;
          next_st.exp_reg = `SEB_EXP_RESET;
          dout_clr        = 1'b1;
        end
        `SEB_OP_ADDR_FIRST: begin
          // Only the 4-bit x3 category at our jumper setting matches
          next_st.lat1 = !cat_mode.wide8 && !cat_mode.expansion
                         && (cat_mode.bits == 4'h4)
                         && (cat_mode.cycles == 2'h3)
                         && (bus.data[3:1] == `SEB_FIRST_BOARD)
                         && (bus.data[0] == JUMPER_IN[0])
                         && own_exp;
          next_st.exp_sel = cat_mode.expansion;
          next_st.lat2 = 1'b0;
          next_st.lat3 = 1'b0;
          next_st.unit = UNIT_NONE;
        end
        `SEB_OP_ADDR_SECOND: begin
          next_st.lat3 = 1'b0;
          next_st.lat2 = 1'b0;
          next_st.unit = UNIT_NONE;
          if (st.lat1 && bus.data[0] == JUMPER_IN[1]) begin
            if (bus.data[3:1] == `SEB_SECOND_DOUT) begin
              next_st.lat2 = 1'b1;
              next_st.unit = UNIT_DOUT;
            end else if (bus.data[3:2] == `SEB_SECOND_DIN_HI) begin
              next_st.lat2 = 1'b1;
              next_st.unit = UNIT_DIN;
            end
          end
        end
        `SEB_OP_ADDR_THIRD: begin
          // Earlier latches are kept, so a lone third cycle re-addresses
          next_st.lat3 = st.lat1 && st.lat2
                         && (bus.data[3:1] == THIRD_MATCH)
                         && (bus.data[0] == JUMPER_IN[2]);
        end
        `SEB_OP_WRITE_DATA: begin
          if (st.exp_sel) begin
            next_st.exp_reg = bus.data[3:0];
          end else if (st.lat3 && st.unit == UNIT_DOUT) begin
            dout_wr = 1'b1;
          end
        end
        `SEB_OP_READ_FIRST,
        `SEB_OP_READ_SECOND: begin
          if (st.lat3 && st.unit == UNIT_DOUT) begin
            next_st.dout = 8'h00;
            next_st.doe  = 8'h01;
          end else if (st.lat3 && st.unit == UNIT_DIN) begin
            if (bus.op == `SEB_OP_READ_FIRST) begin
              next_st.dout     = {4'h0, DIGITAL_IN};
              next_st.doe      = 8'h0F;
              next_st.din_seen = DIGITAL_IN;
            end else begin
              next_st.dout = 8'h00;
              next_st.doe  = 8'h01;
            end
          end
        end
        default: begin
          // Spare read: no register here, lines stay released
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st             <= '0;
      st.strobe_prev <= 1'b1;
      st.unit        <= UNIT_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign BUS_DATA_OUT    = st.dout;
  assign BUS_DATA_OE_OUT = st.doe;
  assign ATTN_REQ_N_OUT  = 1'b0;      // Open drain: never driven high
  assign ATTN_REQ_OE_OUT = st.attn;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence s_fall_op(logic [2:0] code);
    fall && bus.op == code;
  endsequence

  property p_chain;
    st.lat3 |-> st.lat2 && st.lat1;
  endproperty
  a_chain: assert property (p_chain)
    else $error("third latch set without earlier latches");

  property p_reset;
    s_fall_op(`SEB_OP_BUS_RESET) |=> !st.lat1 && !st.lat3 ##1
      DIGITAL_OUT == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("bus reset did not clear board");

  property p_write;
    (s_fall_op(`SEB_OP_WRITE_DATA) and (st.lat3 && st.unit == UNIT_DOUT
      && !st.exp_sel)) |=> ##1 DIGITAL_OUT[$past(bus.data[3:1], 2)] ==
      $past(bus.data[0], 2);
  endproperty
  a_write: assert property (p_write)
    else $error("output bit not written from control write");

  property p_present;
    (fall && !bus.op[2] && bus.op != `SEB_OP_BUS_RESET
      && bus.op != `SEB_OP_READ_SPARE && st.lat3 && st.unit == UNIT_DOUT)
      |=> BUS_DATA_OE_OUT == 8'h01 && BUS_DATA_OUT[0] == 1'b0;
  endproperty
  a_present: assert property (p_present)
    else $error("output board did not drive bit0 low");

  property p_din;
    (s_fall_op(`SEB_OP_READ_FIRST) and (st.lat3 && st.unit == UNIT_DIN))
      |=> BUS_DATA_OE_OUT == 8'h0F && BUS_DATA_OUT[3:0] == $past(DIGITAL_IN);
  endproperty
  a_din: assert property (p_din)
    else $error("input bits not returned on first-way read");

  property p_din_present;
    (s_fall_op(`SEB_OP_READ_SECOND) and (st.lat3 && st.unit == UNIT_DIN))
      |=> BUS_DATA_OE_OUT == 8'h01 && !BUS_DATA_OUT[0];
  endproperty
  a_din_present: assert property (p_din_present)
    else $error("input board did not answer second-way read");

  property p_unselected;
    (fall && !st.lat3) |=> BUS_DATA_OE_OUT == 8'h00;
  endproperty
  a_unselected: assert property (p_unselected)
    else $error("unselected board drove data lines");

  property p_hold;
    (fall && st.lat3 && (bus.op == `SEB_OP_WRITE_DATA || !bus.op[2])
      && bus.op != `SEB_OP_BUS_RESET) |=> st.lat3 && st.unit == $past(st.unit);
  endproperty
  a_hold: assert property (p_hold)
    else $error("selection lost on data access");

  property p_attn;
    (DIGITAL_IN != st.din_seen) |=> ATTN_REQ_OE_OUT && !ATTN_REQ_N_OUT;
  endproperty
  a_attn: assert property (p_attn)
    else $error("attention not pulled low on input change");

  property p_release;
    bus.strobe_n |=> BUS_DATA_OE_OUT == 8'h00;
  endproperty
  a_release: assert property (p_release)
    else $error("data lines still driven after strobe ended");

  property p_spare;
    s_fall_op(`SEB_OP_READ_SPARE) |=> BUS_DATA_OE_OUT == 8'h00;
  endproperty
  a_spare: assert property (p_spare)
    else $error("spare read drove data lines");

  property p_exp_write;
    (s_fall_op(`SEB_OP_WRITE_DATA) and st.exp_sel)
      |=> st.exp_reg == $past(bus.data[3:0]);
  endproperty
  a_exp_write: assert property (p_exp_write)
    else $error("expansion register not loaded from data write");

  property p_exp_block;
    (s_fall_op(`SEB_OP_ADDR_FIRST) and (st.exp_reg != `SEB_EXP_RESET))
      |=> !st.lat1;
  endproperty
  a_exp_block: assert property (p_exp_block)
    else $error("board selected outside its expansion page");

  property p_readdress;
    (s_fall_op(`SEB_OP_ADDR_THIRD) and (st.lat1 && st.lat2))
      |=> st.lat1 && st.lat2
      && st.lat3 == ($past(bus.data[3:0]) == {THIRD_MATCH, JUMPER_IN[2]});
  endproperty
  a_readdress: assert property (p_readdress)
    else $error("lone third address cycle did not re-address");

endmodule

`default_nettype wire

// ==== verilog/seb_params.svh ====
// Constants of the strobed expansion bus slave: bus register offsets,
// operation codes, category nibbles and board decode patterns.
// Assumes inclusion by bare name from the package only; the design modules rely on its macros.
`ifndef SEB_PARAMS_SVH
`define SEB_PARAMS_SVH

// ----------------------------------------------------------------------
// Host-side register offsets, one per operation code
// ----------------------------------------------------------------------
`define SEB_OFS_READ_FIRST   8'hC0
`define SEB_OFS_READ_SECOND  8'hC2
`define SEB_OFS_READ_SPARE   8'hC4
`define SEB_OFS_BUS_RESET    8'hC6
`define SEB_OFS_ADDR_FIRST   8'hC8
`define SEB_OFS_ADDR_SECOND  8'hCA
`define SEB_OFS_ADDR_THIRD   8'hCC
`define SEB_OFS_WRITE_DATA   8'hCE

// ----------------------------------------------------------------------
// Operation codes on the three select lines
// ----------------------------------------------------------------------
`define SEB_OP_READ_FIRST    3'h0
`define SEB_OP_READ_SECOND   3'h1
`define SEB_OP_READ_SPARE    3'h2
`define SEB_OP_BUS_RESET     3'h3
`define SEB_OP_ADDR_FIRST    3'h4
`define SEB_OP_ADDR_SECOND   3'h5
`define SEB_OP_ADDR_THIRD    3'h6
`define SEB_OP_WRITE_DATA    3'h7

// ----------------------------------------------------------------------
// Category nibbles of the first address byte
// ----------------------------------------------------------------------
`define SEB_CAT_4X3_LAST     4'h3
`define SEB_CAT_5X3_LAST     4'h7
`define SEB_CAT_6X3_LAST     4'h9
`define SEB_CAT_6X1          4'hA
`define SEB_CAT_EXPANSION    4'hB
`define SEB_CAT_8X2          4'hC
`define SEB_CAT_8X3          4'hD

// ----------------------------------------------------------------------
// Board decode patterns (bit 0 of each address nibble is the jumper bit)
// ----------------------------------------------------------------------
`define SEB_FIRST_BOARD      3'h0
`define SEB_SECOND_DOUT      3'h0
`define SEB_SECOND_DIN_HI    2'h1
`define SEB_CTRL_VALUE_BIT   0
`define SEB_CTRL_SEL_HI      3
`define SEB_CTRL_SEL_LO      1
`define SEB_EXP_RESET        4'h0

`endif

// ==== verilog/seb_pkg.sv ====
// Types shared by the expansion bus slave modules.
// Assumes seb_params.svh is on the include path.
`include "seb_params.svh"

package seb_pkg;

  // Address category as decoded from the first address byte
  typedef struct packed {
    logic       wide8;
    logic       expansion;
    logic [1:0] cycles;
    logic [3:0] bits;
  } seb_mode_t;

  // One sample of the bus pins
  typedef struct packed {
    logic       strobe_n;
    logic [2:0] op;
    logic [7:0] data;
  } seb_bus_t;

  typedef enum logic [1:0] {
    UNIT_NONE,
    UNIT_DOUT,
    UNIT_DIN
  } seb_unit_t;

endpackage

// ==== verilog/seb_cat_decode.sv ====
// Decodes the low nibble of the first address byte into an address mode.
// Purely combinational; the caller samples it on the first address cycle.
`timescale 1ns/1ps
`default_nettype none

module seb_cat_decode
  import seb_pkg::*;
(
  input  wire logic [3:0] nibble_in,
  output seb_mode_t       mode_out
);

  always_comb begin
    mode_out = '{wide8: 1'b0, expansion: 1'b0, cycles: 2'h3, bits: 4'h4};
    if (nibble_in <= `SEB_CAT_4X3_LAST) begin
      mode_out.bits = 4'h4;
    end else if (nibble_in <= `SEB_CAT_5X3_LAST) begin
      mode_out.bits = 4'h5;
    end else if (nibble_in <= `SEB_CAT_6X3_LAST) begin
      mode_out.bits = 4'h6;
    end else if (nibble_in == `SEB_CAT_6X1) begin
      mode_out.bits   = 4'h6;
      mode_out.cycles = 2'h1;
    end else if (nibble_in == `SEB_CAT_EXPANSION) begin
      mode_out.expansion = 1'b1;
      mode_out.cycles    = 2'h1;
    end else begin
      mode_out.wide8 = 1'b1;
      mode_out.bits  = 4'h8;
      if (nibble_in == `SEB_CAT_8X2) begin
        mode_out.cycles = 2'h2;
      end else if (nibble_in != `SEB_CAT_8X3) begin
        mode_out.cycles = 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== verilog/seb_dout_bank.sv ====
// Bank of latched digital output bits, one written at a time.
// Assumes the caller gives a one-cycle write pulse and a clear pulse.
`timescale 1ns/1ps
`default_nettype none

module seb_dout_bank
  import seb_pkg::*;
#(
  parameter int N_OUT = 8
)(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             wr_in,
  input  wire logic             clr_in,
  input  wire logic [2:0]       sel_in,
  input  wire logic             val_in,
  output logic      [N_OUT-1:0] bits_out
);

  if (N_OUT != 8) begin : g_check
    $error("seb_dout_bank: three select bits need exactly 8 outputs");
  end

  typedef struct packed {
    logic [N_OUT-1:0] bits;
  } seb_bank_t;

  seb_bank_t st;
  seb_bank_t next_st;

  // ----------------------------------------------------------------------
  // Per-bit update
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    for (int i = 0; i < N_OUT; i++) begin
      if (clr_in) begin
        next_st.bits[i] = 1'b0;
      end else if (wr_in && (sel_in == 3'(i))) begin
        next_st.bits[i] = val_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bits_out = st.bits;

endmodule

`default_nettype wire

// ==== tb/seb_host_model.sv ====
// Host controller model: frames each bus operation with one strobe pulse.
// Assumes the bench resolves the data lines, with pull-ups when released.
`timescale 1ns/1ps
`default_nettype none

module seb_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_in,
  output logic            strobe_n_out,
  output logic      [2:0] op_out,
  output logic      [7:0] data_out,
  output logic            drive_out,
  output logic      [7:0] rd_data_out,
  output var int          rd_count_out
);
  initial begin
    strobe_n_out = 1'b1;
    op_out       = 3'h0;
    data_out     = 8'hFF;
    drive_out    = 1'b0;
    rd_data_out  = 8'h00;
    rd_count_out = 0;
  end

  // ----------------------------------------------------------------
  // One operation, strobe low for hold edges
  // ----------------------------------------------------------------
  task automatic xfer(input logic [2:0] o, input logic [7:0] d,
                      input int hold);
    @(posedge clk_in);
    strobe_n_out <= 1'b0;
    op_out       <= o;
    data_out     <= d;
    drive_out    <= o[2];
    repeat (hold) @(posedge clk_in);
    if (o < 3'h3) begin
      rd_data_out  <= bus_in;
      rd_count_out <= rd_count_out + 1;
    end
    strobe_n_out <= 1'b1;
    // Released lines must not keep showing the last value
    op_out       <= ~o;
    data_out     <= ~d;
    drive_out    <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the expansion board slave.
// Assumes seb_host_model as bus master and pull-ups on shared lines.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [2:0] TM = 3'h5;
  localparam logic [3:0] A1 = 4'h1;
  localparam logic [3:0] A3 = {TM, 1'b1};
  logic        clk, rst_n, strobe_n, hdrive, attn_n, attn_oe;
  logic [2:0]  jumper, op;
  logic [3:0]  din;
  logic [7:0]  bus, dq, doe, dout, hdata, rd_data, r, exp_out, last_out;
  logic [15:0] e;
  logic [31:0] lfsr;
  int          rd_count, seen_rd, miscompares, n_compared;
  logic [15:0] rd_q[$];
  logic [7:0]  out_q[$];

  // Host wins, then board drive, else pull-up
  assign bus = hdrive ? hdata : ((doe & dq) | ~doe);

  seb_board #(.THIRD_MATCH(TM), .N_OUT(8), .N_IN(4)) uut (
    .CLK_IN(clk), .RSTN_IN(rst_n), .BUS_STROBE_N_IN(strobe_n),
    .OP_SELECT_IN(op), .BUS_DATA_IN(bus), .JUMPER_IN(jumper),
    .DIGITAL_IN(din), .BUS_DATA_OUT(dq), .BUS_DATA_OE_OUT(doe),
    .ATTN_REQ_N_OUT(attn_n), .ATTN_REQ_OE_OUT(attn_oe),
    .DIGITAL_OUT(dout));

  seb_host_model host (
    .clk_in(clk), .bus_in(bus), .strobe_n_out(strobe_n), .op_out(op),
    .data_out(hdata), .drive_out(hdrive), .rd_data_out(rd_data),
    .rd_count_out(rd_count));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Upper nibble random: a 4-bit board must ignore it
  task automatic cyc(input logic [2:0] o, input logic [3:0] n,
                     input int hold);
    logic [7:0] u;
    u = rnd();
    host.xfer(o, {u[7:4], n}, hold);
  endtask

  task automatic addr(input logic [3:0] a1, a2, a3);
    cyc(3'h4, a1, 1);
    cyc(3'h5, a2, 1);
    cyc(3'h6, a3, 1);
  endtask

  task automatic rd(input logic [2:0] o, input logic [7:0] m, v);
    rd_q.push_back({m, v});
    cyc(o, 4'hF, 3);
  endtask

  task automatic put(input logic [2:0] i, input logic v);
    if (exp_out[i] !== v) begin
      exp_out[i] = v;
      out_q.push_back(exp_out);
    end
    cyc(3'h7, {i, v}, 1);
  endtask

  task automatic test_done();
    $display("compared=%0d mismatches=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_count != seen_rd) begin
      seen_rd = rd_count;
      e = rd_q.size() > 0 ? rd_q.pop_front() : {8'hFF, ~rd_data};
      check(rd_data & e[15:8], e[7:0]);
    end
    if (dout !== last_out) begin
      last_out = dout;
      check(dout, out_q.size() > 0 ? out_q.pop_front() : ~dout);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    lfsr = 32'hA829;
    miscompares = 0;
    n_compared = 0;
    seen_rd = 0;
    rst_n = 1'b0;
    jumper = 3'b101;
    din = 4'h0;
    exp_out = 8'h00;
    last_out = 8'h00;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h0, 8'hFF, 8'hFF);
    $display("test idle done");
    addr(A1, 4'h0, A3);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      put(i[2:0], r[0]);
    end
    rd(3'h0, 8'h01, 8'h00);
    rd(3'h1, 8'h01, 8'h00);
    rd(3'h2, 8'hFF, 8'hFF);
    $display("test outputs done");
    cyc(3'h6, 4'h0, 1);
    rd(3'h0, 8'hFF, 8'hFF);
    cyc(3'h7, {3'h0, ~exp_out[0]}, 1);
    cyc(3'h6, A3, 1);
    rd(3'h0, 8'h01, 8'h00);
    $display("test readdress done");
    r = rnd();
    addr(A1, {2'b01, r[0], 1'b0}, A3);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      din <= r[3:0];
      rd(3'h0, 8'h0F, {4'h0, r[3:0]});
    end
    rd(3'h1, 8'h01, 8'h00);
    din <= ~r[3:0];
    repeat (4) @(posedge clk);
    check({7'h0, attn_oe}, 8'h01);
    check({7'h0, attn_n}, 8'h00);
    rd(3'h0, 8'h0F, {4'h0, ~r[3:0]});
    repeat (4) @(posedge clk);
    check({7'h0, attn_oe}, 8'h00);
    $display("test inputs done");
    for (int c = 0; c < 16; c++) begin
      if (c != 1) begin
        addr(A1, 4'h0, A3);
        addr(c[3:0], 4'h0, A3);
        rd(3'h0, 8'hFF, 8'hFF);
      end
    end
    $display("test categories done");
    cyc(3'h4, 4'hB, 1);
    cyc(3'h7, 4'h5, 1);
    addr(A1, 4'h0, A3);
    rd(3'h0, 8'hFF, 8'hFF);
    cyc(3'h4, 4'hB, 1);
    cyc(3'h7, 4'h0, 1);
    addr(A1, 4'h0, A3);
    rd(3'h0, 8'h01, 8'h00);
    $display("test expansion done");
    put(3'h7, 1'b1);
    cyc(3'h4, 4'hB, 1);
    cyc(3'h7, 4'h9, 1);
    exp_out = 8'h00;
    out_q.push_back(8'h00);
    cyc(3'h3, 4'hF, 2);
    repeat (8) @(posedge clk);
    rd(3'h0, 8'hFF, 8'hFF);
    addr(A1, 4'h0, A3);
    rd(3'h0, 8'h01, 8'h00);
    $display("test bus reset done");
    put(3'h2, 1'b1);
    repeat (4) @(posedge clk);
    exp_out = 8'h00;
    out_q.push_back(8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h0, 8'hFF, 8'hFF);
    $display("test async reset done");
    repeat (8) @(posedge clk);
    check(8'(rd_q.size() + out_q.size()), 8'h00);
    test_done();
  end
endmodule

`default_nettype wire
